//--- rtl/rts_crc.sv
// Serial packet checksum engine, CCITT or IBM polynomial
`timescale 1ns/1ps
`default_nettype none
`include "rts_regs.svh"
module rts_crc
	import rts_pkg::*;
(
	input  wire logic        i_mclk,
	input  wire logic        i_rst_n,
	input  wire logic        i_ibm,
	input  wire logic        i_clear,
	input  wire logic        i_byte_valid,
	input  wire logic [7:0]  i_byte,
	output logic      [15:0] o_crc
);
	logic [15:0] crc_q;

	// One byte, most significant bit first
	function automatic logic [15:0] rts_crc_byte(input logic [15:0] c, input logic [7:0] d,
	                                             input logic [15:0] p);
		logic [15:0] r;
		r = c;
		for (int i = 7; i >= 0; i--) begin
			if (r[15] ^ d[i]) begin
				r = {r[14:0], 1'b0} ^ p;
			end else begin
				r = {r[14:0], 1'b0};
			end
		end
		return r;
	endfunction

	// ============================================================
	// Running remainder
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			crc_q <= `RTS_SEED_CCITT;
		end else if (i_clear) begin
			crc_q <= i_ibm ? `RTS_SEED_IBM : `RTS_SEED_CCITT;
		end else if (i_byte_valid) begin
			crc_q <= rts_crc_byte(crc_q, i_byte, i_ibm ? `RTS_POLY_IBM : `RTS_POLY_CCITT); // R18
		end
	end

	// CCITT result is inverted, IBM result is used as is
	assign o_crc = i_ibm ? crc_q : ~crc_q; // R20
endmodule
`default_nettype wire

//--- rtl/rts_device.sv
// Radio top sequencer: listen and beacon scenarios
`timescale 1ns/1ps
`default_nettype none
`include "rts_regs.svh"
// Overview of operation
// (R01) Listen mostly idles, RX windows periodically
// (R02) Preamble listen wakes every T1+T2, RX T2
// (R03) Preamble found stops sequencer, stays RX
// (R04) Packet received raises host interrupt
// (R05) Preamble event on pin four, code 11
// (R06) Listen_interval_timer bounds RX while no preamble
// (R07) Sender preamble at least T1+2*T2
// (R08) Sync listen: RX only for expiry window
// (R09) Preamble then no sync: resume polling
// (R10) Sync match: interrupt, stop, stay RX
// (R11) After-RX code 101 stops on sync
// (R12) Host sets T1 to 64 us minimum
// (R13) Sender preamble is T2 minus sync time
// (R14) Beacon repeats payload with enable bit
// (R15) Beacon TX each period, idle on done
// (R16) Beacon loops until halt bit set
// (R17) After-TX code 0 returns to low power
// (R18) CCITT checksum, bitwise per byte
// (R19) Example field settings as listed
// (R20) IBM mode; CCITT result inverted
module rts_device
	import rts_pkg::*;
(
	input  wire logic        i_mclk,
	input  wire logic        i_rst_n,
	rts_if.dev               bus,
	input  wire logic        i_preamble_found_event,
	input  wire logic        i_sync_word_match_event,
	input  wire logic        i_payload_complete_event,
	input  wire logic        i_transmit_done_event,
	input  wire logic        i_byte_valid,
	input  wire logic [7:0]  i_byte,
	output logic             o_rc_only,
	output logic             o_tx_launch
);
	rts_state_t  state_q;
	logic [15:0] tick_cnt_q;
	logic        tick;
	logic [7:0]  tmr_q;
	logic        t2_phase_q;
	logic [7:0]  win_q;
	logic [7:0]  extra_q;
	logic        pre_s1_q, pre_s2_q, syn_s1_q, syn_s2_q, pay_s1_q, pay_s2_q, txd_s1_q, txd_s2_q;
	logic        pre_lat_q, syn_lat_q, irq_q;

	// Timer length in ticks; zero treated as one to keep the loop alive
	function automatic logic [7:0] rts_len(input logic [7:0] v);
		return (v == 8'h00) ? 8'h01 : v;
	endfunction

	// ============================================================
	// Event pins come from the radio domain: two flops each
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			{pre_s1_q, pre_s2_q, syn_s1_q, syn_s2_q} <= 4'h0;
			{pay_s1_q, pay_s2_q, txd_s1_q, txd_s2_q} <= 4'h0;
		end else begin
			pre_s1_q <= i_preamble_found_event;
			pre_s2_q <= pre_s1_q;
			syn_s1_q <= i_sync_word_match_event;
			syn_s2_q <= syn_s1_q;
			pay_s1_q <= i_payload_complete_event;
			pay_s2_q <= pay_s1_q;
			txd_s1_q <= i_transmit_done_event;
			txd_s2_q <= txd_s1_q;
		end
	end

	// ============================================================
	// 64 us timer base enable
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tick_cnt_q <= 16'h0000;
		end else if (tick_cnt_q == 16'(`RTS_TICK_CYC - 1)) begin
			tick_cnt_q <= 16'h0000;
		end else begin
			tick_cnt_q <= tick_cnt_q + 16'h0001;
		end
	end
	assign tick = (tick_cnt_q == 16'(`RTS_TICK_CYC - 1));

	// ============================================================
	// Sequencer state machine
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_q    <= RTS_OFF;
			tmr_q      <= 8'h00;
			win_q      <= 8'h00;
			t2_phase_q <= 1'b0;
			extra_q    <= 8'h00;
		end else if (bus.seq_halt_bit) begin
			state_q <= RTS_OFF; // R16
			extra_q <= 8'h00;
		end else begin
			unique case (state_q)
				RTS_OFF: begin
					if (bus.start && bus.after_launch_transition == `RTS_START_TO_LP) begin
						state_q <= RTS_LP; // R19
					end
				end
				RTS_LP: begin
					// Idle lasts sleep_interval_timer plus the unused part of listen_interval_timer, so the
					// period stays T1+T2; the 8-bit sum wraps if both are very long
					extra_q <= 8'h00;
					if (bus.low_power_target_select == `RTS_LP_TO_IDLE) begin
						state_q    <= RTS_IDLE; // R19
						tmr_q      <= rts_len(bus.sleep_interval_timer) + extra_q; // R08 R15
						t2_phase_q <= 1'b0;
					end else begin
						state_q <= RTS_OFF;
					end
				end
				RTS_IDLE: begin
					// Sleep_interval_timer expiry wakes RX or TX; radio is RC-only meanwhile
					if (tick && tmr_q == 8'h01) begin
						tmr_q <= rts_len(bus.listen_interval_timer);
						win_q <= rts_len(bus.preamble_wait_limit);
						if (bus.after_idle_transition == `RTS_IDLE_TO_RX) begin
							state_q <= RTS_RX; // R01
						end else if (bus.repeat_tx_enable) begin
							state_q <= RTS_TX; // R14
						end else begin
							state_q <= RTS_OFF;
						end
					end else if (tick) begin
						tmr_q <= tmr_q - 8'h01;
					end
				end
				RTS_RX: begin
					if (bus.after_rx_transition == `RTS_RX_OFF_ON_PRE && pre_s2_q) begin
						state_q <= RTS_RXPRE; // R03
					end else if (bus.after_rx_transition == `RTS_RX_OFF_ON_SYNC && syn_s2_q) begin
						state_q <= RTS_RXPRE; // R10 R11
					end else if (bus.after_rx_transition == `RTS_RX_OFF_ON_SYNC && pre_s2_q) begin
						t2_phase_q <= 1'b1; // R09
					end
					if (tick) begin
						tmr_q <= tmr_q - 8'h01;
						if (win_q != 8'h00) begin
							win_q <= win_q - 8'h01;
						end
					end
					// Expiry window ends RX unless a preamble was seen (R08)
					if (tick && bus.after_rx_transition == `RTS_RX_OFF_ON_SYNC && !t2_phase_q
					    && !pre_s2_q && win_q == 8'h01
					    && bus.after_rx_expiry_transition == `RTS_EXP_TO_LP) begin
						state_q <= RTS_LP; // R08
						extra_q <= tmr_q - 8'h01; // R08
					end else if (tick && tmr_q == 8'h01 && !syn_s2_q
					             && !(bus.after_rx_transition == `RTS_RX_OFF_ON_PRE && pre_s2_q)) begin
						state_q <= RTS_LP; // R02 R06 R09
					end
				end
				RTS_TX: begin
					// Packet sent returns to low power; rest of listen_interval_timer moves to idle
					if (tick && tmr_q != 8'h00) begin
						tmr_q <= tmr_q - 8'h01;
					end
					if (txd_s2_q && bus.after_tx_transition == `RTS_TX_TO_LP) begin
						state_q <= RTS_LP; // R15 R17
						extra_q <= (tick && tmr_q != 8'h00) ? tmr_q - 8'h01 : tmr_q; // R15
					end
				end
				RTS_RXPRE: begin
					// Sequencer off, receiver held until host changes mode
					if (!bus.start) begin
						state_q <= RTS_OFF; // R03 R10
					end
				end
			endcase
		end
	end

	// ============================================================
	// Event latches feeding the interrupt pins; set wins over clear
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pre_lat_q <= 1'b0;
			syn_lat_q <= 1'b0;
			irq_q     <= 1'b0;
		end else begin
			pre_lat_q <= pre_s2_q || (pre_lat_q && state_q != RTS_OFF);
			syn_lat_q <= syn_s2_q || (syn_lat_q && state_q != RTS_OFF);
			irq_q     <= pay_s2_q || (irq_q && bus.start); // R04
		end
	end

	// Pin four only carries the preamble event with code 11 and route bit set
	assign bus.irq_pin_four = pre_lat_q && bus.pin_four_map == `RTS_PRE_ROUTE_CODE
	                          && bus.preamble_route_select; // R05
	assign bus.irq_pin_two  = syn_lat_q; // R10
	assign bus.packet_irq   = irq_q;
	assign bus.seq_running  = (state_q != RTS_OFF) && (state_q != RTS_RXPRE);
	assign bus.radio_mode   = (state_q == RTS_RX || state_q == RTS_RXPRE) ? RTS_RADIO_RX :
	                          (state_q == RTS_TX) ? RTS_RADIO_TX : RTS_RADIO_SLEEP;
	assign o_rc_only        = (state_q == RTS_IDLE) && (bus.idle_kind_select == `RTS_IDLE_SLEEP);
	assign o_tx_launch      = (state_q == RTS_TX);

	// ============================================================
	// Packet checksum
	rts_crc u_crc (
		.i_mclk       (i_mclk),
		.i_rst_n      (i_rst_n),
		.i_ibm        (bus.crc_ibm),
		.i_clear      (state_q == RTS_LP),
		.i_byte_valid (i_byte_valid),
		.i_byte       (i_byte),
		.o_crc        (bus.crc_value)
	);
endmodule
`default_nettype wire

//--- rtl/rts_host.sv
// Host controller end: programs a scenario and watches the event pins
`timescale 1ns/1ps
`default_nettype none
`include "rts_regs.svh"
module rts_host
	import rts_pkg::*;
(
	input  wire logic        i_mclk,
	input  wire logic        i_rst_n,
	rts_if.host              bus,
	input  wire logic [1:0]  i_scenario,
	input  wire logic        i_go,
	input  wire logic        i_stop,
	input  wire logic        i_resume,
	input  wire logic [7:0]  i_t1,
	input  wire logic [7:0]  i_t2,
	input  wire logic [7:0]  i_win,
	output logic             o_event_seen,
	output logic             o_rx_held
);
	logic       start_q, halt_q, seen_q;
	logic [1:0] scen_q;

	// ============================================================
	// Run control; halt bit ends the beacon loop
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			start_q <= 1'b0;
			halt_q  <= 1'b0;
			scen_q  <= 2'h0;
		end else if (i_go) begin
			start_q <= 1'b1;
			halt_q  <= 1'b0;
			scen_q  <= i_scenario;
		end else if (i_stop) begin
			halt_q <= 1'b1; // R16
		end else if (i_resume) begin
			start_q <= 1'b0;
		end
	end

	// Event seen on pin four or two; new event wins over resume
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			seen_q <= 1'b0;
		end else begin
			seen_q <= bus.irq_pin_four || bus.irq_pin_two || (seen_q && !i_resume);
		end
	end

	// ============================================================
	// Field settings; scenario 0 preamble listen, 1 sync listen, 2 beacon,
	// 3 preamble listen with the IBM checksum
	assign bus.start                      = start_q;
	assign bus.seq_halt_bit               = halt_q;
	assign bus.idle_kind_select           = `RTS_IDLE_SLEEP;
	assign bus.after_launch_transition    = `RTS_START_TO_LP;
	assign bus.low_power_target_select    = `RTS_LP_TO_IDLE;
	assign bus.after_idle_transition      = (scen_q == 2'h2) ? `RTS_IDLE_TO_TX : `RTS_IDLE_TO_RX;
	assign bus.after_rx_transition        = (scen_q == 2'h1) ? `RTS_RX_OFF_ON_SYNC : `RTS_RX_OFF_ON_PRE;
	assign bus.after_rx_expiry_transition = `RTS_EXP_TO_LP;
	assign bus.after_tx_transition        = `RTS_TX_TO_LP;
	assign bus.repeat_tx_enable           = (scen_q == 2'h2); // R14
	assign bus.preamble_route_select      = 1'b1; // R05
	assign bus.pin_four_map               = `RTS_PRE_ROUTE_CODE;
	assign bus.sleep_interval_timer       = (scen_q == 2'h1) ? 8'h01 : i_t1; // R12
	assign bus.listen_interval_timer      = i_t2;
	assign bus.preamble_wait_limit        = i_win;
	assign bus.crc_ibm                    = (scen_q == 2'h3); // R20
	assign o_event_seen                   = seen_q;
	assign o_rx_held                      = start_q && !bus.seq_running
	                                        && bus.radio_mode == RTS_RADIO_RX;
endmodule
`default_nettype wire

//--- rtl/rts_if.sv
// Interface joining the sequencer device to its host controller
`timescale 1ns/1ps
`default_nettype none
interface rts_if;
	import rts_pkg::*;
	// Configuration driven by the host
	logic       start;
	logic       seq_halt_bit;
	logic       idle_kind_select;
	logic [1:0] after_launch_transition;
	logic       low_power_target_select;
	logic       after_idle_transition;
	logic [2:0] after_rx_transition;
	logic [1:0] after_rx_expiry_transition;
	logic       after_tx_transition;
	logic       repeat_tx_enable;
	logic       preamble_route_select;
	logic [1:0] pin_four_map;
	logic [7:0] sleep_interval_timer;
	logic [7:0] listen_interval_timer;
	logic [7:0] preamble_wait_limit;
	logic       crc_ibm;
	// Device status
	logic       irq_pin_four;
	logic       irq_pin_two;
	logic       seq_running;
	logic       packet_irq;
	rts_radio_t radio_mode;
	logic [15:0] crc_value;
	modport dev (
		input  start, seq_halt_bit, idle_kind_select, after_launch_transition,
		       low_power_target_select, after_idle_transition, after_rx_transition,
		       after_rx_expiry_transition, after_tx_transition, repeat_tx_enable,
		       preamble_route_select, pin_four_map, sleep_interval_timer,
		       listen_interval_timer, preamble_wait_limit, crc_ibm,
		output irq_pin_four, irq_pin_two, seq_running, packet_irq, radio_mode, crc_value
	);
	modport host (
		output start, seq_halt_bit, idle_kind_select, after_launch_transition,
		       low_power_target_select, after_idle_transition, after_rx_transition,
		       after_rx_expiry_transition, after_tx_transition, repeat_tx_enable,
		       preamble_route_select, pin_four_map, sleep_interval_timer,
		       listen_interval_timer, preamble_wait_limit, crc_ibm,
		input  irq_pin_four, irq_pin_two, seq_running, packet_irq, radio_mode, crc_value
	);
endinterface
`default_nettype wire

//--- rtl/rts_pkg.sv
// Types shared by the radio top sequencer ends
package rts_pkg;
	typedef enum logic [5:0] {
		RTS_OFF   = 6'h01,
		RTS_LP    = 6'h02,
		RTS_IDLE  = 6'h04,
		RTS_RX    = 6'h08,
		RTS_TX    = 6'h10,
		RTS_RXPRE = 6'h20
	} rts_state_t;
	typedef enum logic [1:0] {
		RTS_RADIO_SLEEP = 2'h0,
		RTS_RADIO_RX    = 2'h1,
		RTS_RADIO_TX    = 2'h2
	} rts_radio_t;
endpackage

//--- rtl/rts_regs.svh
// Constants of the radio top sequencer: field codes and timer defaults
`ifndef RTS_REGS_SVH
`define RTS_REGS_SVH

// ============================================================
// Transition field codes
`define RTS_IDLE_SLEEP        1'b1
`define RTS_START_TO_LP       2'h0
`define RTS_LP_TO_IDLE        1'b1
`define RTS_IDLE_TO_RX        1'b1
`define RTS_IDLE_TO_TX        1'b0
`define RTS_RX_OFF_ON_PRE     3'h6
`define RTS_RX_OFF_ON_SYNC    3'h5
`define RTS_EXP_TO_LP         2'h2
`define RTS_TX_TO_LP          1'b0
`define RTS_PRE_ROUTE_CODE    2'h3
// ============================================================
// Timer tick: 64 us base at 100 MHz
`define RTS_TICK_NS           64000
`define RTS_CLK_NS            10
`define RTS_TICK_CYC          (`RTS_TICK_NS / `RTS_CLK_NS)
// ============================================================
// CRC
`define RTS_POLY_CCITT        16'h1021
`define RTS_POLY_IBM          16'h8005
`define RTS_SEED_CCITT        16'h1D0F
`define RTS_SEED_IBM          16'hFFFF

`endif

//--- tb/rts_monitor.sv
// Concurrent checks on the interface joining the sequencer ends
`timescale 1ns/1ps
`default_nettype none
`include "rts_regs.svh"
module rts_monitor
	import rts_pkg::*;
(
	input wire logic       i_mclk,
	input wire logic       i_rst_n,
	input wire logic       start,
	input wire logic       seq_halt_bit,
	input wire logic       after_idle_transition,
	input wire logic [2:0] after_rx_transition,
	input wire logic       preamble_route_select,
	input wire logic [1:0] pin_four_map,
	input wire logic [7:0] listen_interval_timer,
	input wire logic       irq_pin_four,
	input wire logic       irq_pin_two,
	input wire logic       seq_running,
	input wire logic       packet_irq,
	input wire logic [1:0] radio_mode
);
	localparam int TICK = `RTS_TICK_CYC;
	logic [31:0] rx_cnt_q;
	logic [31:0] rx_lim;
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);
	// ============================================================
	// Helper: length of the current unbroken receive stretch
	assign rx_lim = ({24'h0, listen_interval_timer} + 32'h2) * 32'(TICK);
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rx_cnt_q <= 32'h0;
		end else if (radio_mode == RTS_RADIO_RX) begin
			rx_cnt_q <= rx_cnt_q + 32'h1;
		end else begin
			rx_cnt_q <= 32'h0;
		end
	end
	// ============================================================
	// Properties; slack of two ticks covers a partial first tick
	property p_halt_stop;
		seq_halt_bit ##1 seq_halt_bit |-> !seq_running;
	endproperty
	property p_pin4_route;
		$rose(irq_pin_four) |-> pin_four_map == `RTS_PRE_ROUTE_CODE && preamble_route_select;
	endproperty
	property p_pin4_rx;
		$rose(irq_pin_four) |-> radio_mode == RTS_RADIO_RX;
	endproperty
	property p_pin4_hold;
		irq_pin_four && start && !seq_halt_bit |=> irq_pin_four;
	endproperty
	property p_held_rx;
		(irq_pin_four && start && !seq_halt_bit) [*2] |-> radio_mode == RTS_RADIO_RX;
	endproperty
	property p_sync_hold;
		$rose(irq_pin_two) && radio_mode == RTS_RADIO_RX && after_rx_transition == 3'h5 && start
			|=> (radio_mode == RTS_RADIO_RX) [*8];
	endproperty
	property p_rx_entry;
		$rose(radio_mode == RTS_RADIO_RX) |-> after_idle_transition == 1'b1;
	endproperty
	property p_tx_entry;
		$rose(radio_mode == RTS_RADIO_TX) |-> after_idle_transition == 1'b0;
	endproperty
	property p_rx_bound;
		rx_cnt_q <= rx_lim || irq_pin_four || irq_pin_two;
	endproperty
	property p_off_sleep;
		(!start) [*4] |-> radio_mode == RTS_RADIO_SLEEP;
	endproperty
	property p_packet_hold;
		packet_irq && start |=> packet_irq;
	endproperty
	a_halt_stop: assert property (p_halt_stop) else $error("halt did not stop sequencer");
	a_pin4_route: assert property (p_pin4_route) else $error("pin four without routing");
	a_pin4_rx: assert property (p_pin4_rx) else $error("preamble flag outside receive");
	a_pin4_hold: assert property (p_pin4_hold) else $error("pin four dropped early");
	a_held_rx: assert property (p_held_rx) else $error("receive not held");
	a_sync_hold: assert property (p_sync_hold) else $error("left receive after sync");
	a_rx_entry: assert property (p_rx_entry) else $error("receive entered wrongly");
	a_tx_entry: assert property (p_tx_entry) else $error("transmit entered wrongly");
	a_rx_bound: assert property (p_rx_bound) else $error("receive window too long");
	a_off_sleep: assert property (p_off_sleep) else $error("radio awake while off");
	a_packet_hold: assert property (p_packet_hold) else $error("packet flag dropped");
	c_pin4: cover property ($rose(irq_pin_four));
	c_pin2: cover property ($rose(irq_pin_two));
	c_tx: cover property ($rose(radio_mode == RTS_RADIO_TX));
	c_pkt: cover property ($rose(packet_irq));
endmodule
`default_nettype wire

//--- tb/tb_radio_top_sequencer_listen_beacon.sv
// Testbench: both sequencer ends joined, listen and beacon scenarios
`timescale 1ns/1ps
`default_nettype none
`include "rts_regs.svh"
module tb_radio_top_sequencer_listen_beacon
	import rts_pkg::*;
;
	logic        i_mclk;
	logic        i_rst_n;
	logic [7:0]  pl;
	logic [7:0]  byte_d;
	logic [1:0]  scen;
	logic [7:0]  t1;
	logic [7:0]  t2;
	logic [7:0]  win;
	logic        seen;
	logic        held;
	logic        rc_only;
	logic        tx_launch;
	logic [15:0] ce;
	logic [15:0] cp;
	int          fails;
	int          num_checks;
	// ============================================================
	// Ends, interface and checker; pl holds go, stop, resume, events, byte strobe
	rts_if u_rts_if ();
	rts_device u_rts_device (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .bus(u_rts_if),
		.i_preamble_found_event(pl[3]), .i_sync_word_match_event(pl[4]),
		.i_payload_complete_event(pl[5]), .i_transmit_done_event(pl[6]),
		.i_byte_valid(pl[7]), .i_byte(byte_d), .o_rc_only(rc_only), .o_tx_launch(tx_launch));
	rts_host u_rts_host (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .bus(u_rts_if), .i_scenario(scen),
		.i_go(pl[0]), .i_stop(pl[1]), .i_resume(pl[2]), .i_t1(t1), .i_t2(t2), .i_win(win),
		.o_event_seen(seen), .o_rx_held(held));
	rts_monitor u_rts_monitor (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .start(u_rts_if.start),
		.seq_halt_bit(u_rts_if.seq_halt_bit), .after_idle_transition(u_rts_if.after_idle_transition),
		.after_rx_transition(u_rts_if.after_rx_transition),
		.preamble_route_select(u_rts_if.preamble_route_select),
		.pin_four_map(u_rts_if.pin_four_map), .listen_interval_timer(u_rts_if.listen_interval_timer),
		.irq_pin_four(u_rts_if.irq_pin_four), .irq_pin_two(u_rts_if.irq_pin_two),
		.seq_running(u_rts_if.seq_running), .packet_irq(u_rts_if.packet_irq),
		.radio_mode(u_rts_if.radio_mode));
	// ============================================================
	// Clock
	initial begin
		i_mclk = 1'b0;
		forever #5 i_mclk = ~i_mclk;
	end
	// ============================================================
	// Helpers
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic conclude();
		if (fails == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge i_mclk);
	endtask
	// One-cycle strobe; a synchroniser flop sees it on its next edge
	task automatic pulse(input int k);
		@(posedge i_mclk);
		pl[k] <= 1'b1;
		@(posedge i_mclk);
		pl[k] <= 1'b0;
	endtask
	// Bounded wait; running out ends the run as a mismatch
	task automatic wait_mode(input rts_radio_t m, input int lim);
		int n;
		n = 0;
		while (u_rts_if.radio_mode !== m && n < lim) begin
			@(posedge i_mclk);
			n++;
		end
		if (u_rts_if.radio_mode !== m) begin
			fails++;
			$display("BAD radio_mode expected %h seen %h", m, u_rts_if.radio_mode);
			conclude();
		end
	endtask
	// Launch a scenario and look at the shared field settings while idle
	task automatic run(input logic [1:0] s, input logic [7:0] a, input logic [7:0] b,
		input logic [7:0] w);
		@(posedge i_mclk);
		scen <= s;
		t1 <= a;
		t2 <= b;
		win <= w;
		pulse(0);
		cyc(6);
		chk("rc_only", 16'h1, {15'h0, rc_only});
		chk("idle_kind", 16'h1, {15'h0, u_rts_if.idle_kind_select});
		chk("launch", 16'h0, {14'h0, u_rts_if.after_launch_transition});
		chk("lp_target", 16'h1, {15'h0, u_rts_if.low_power_target_select});
	endtask
	// Bitwise checksum step, most significant bit first
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d,
		input logic [15:0] p);
		for (int i = 0; i < 8; i++) begin
			c = {c[14:0], 1'b0} ^ ((c[15] ^ d[7]) ? p : 16'h0);
			d = {d[6:0], 1'b0};
		end
		return c;
	endfunction
	// ============================================================
	// Main sequence
	initial begin
		fails = 0;
		num_checks = 0;
		pl = 8'h00;
		byte_d = 8'h00;
		scen = 2'h0;
		t1 = 8'h01;
		t2 = 8'h01;
		win = 8'h01;
		i_rst_n = 1'b0;
		cyc(16);
		i_rst_n <= 1'b1;
		cyc(2);
		chk("seq_running", 16'h0, {15'h0, u_rts_if.seq_running});
		// Checksum: CCITT from reset, then IBM after a launch and halt clears it
		for (int m = 0; m < 2; m++) begin
			if (m == 1) begin
				scen <= 2'h3;
				pulse(0);
				pulse(1);
				cyc(4);
			end
			cp = u_rts_if.crc_ibm ? `RTS_POLY_IBM : `RTS_POLY_CCITT;
			ce = u_rts_if.crc_ibm ? `RTS_SEED_IBM : `RTS_SEED_CCITT;
			chk("crc_reset", u_rts_if.crc_ibm ? ce : ~ce, u_rts_if.crc_value);
			for (int k = 0; k < 2; k++) begin
				byte_d <= (k == 0) ? 8'h5A : 8'hC3;
				pulse(7);
				ce = crc_step(ce, (k == 0) ? 8'h5A : 8'hC3, cp);
				cyc(20);
				chk("crc_value", u_rts_if.crc_ibm ? ce : ~ce, u_rts_if.crc_value);
			end
		end
		// Preamble listen: empty window, then a preamble stops and holds receive
		run(2'h0, 8'h01, 8'h01, 8'h01);
		chk("pin_map", 16'h3, {14'h0, u_rts_if.pin_four_map});
		chk("route", 16'h1, {15'h0, u_rts_if.preamble_route_select});
		wait_mode(RTS_RADIO_RX, 20000);
		wait_mode(RTS_RADIO_SLEEP, 6500);
		chk("pin_four", 16'h0, {15'h0, u_rts_if.irq_pin_four});
		wait_mode(RTS_RADIO_RX, 14000);
		pulse(3);
		cyc(8);
		chk("pin_four", 16'h1, {15'h0, u_rts_if.irq_pin_four});
		chk("rx_held", 16'h1, {15'h0, held});
		chk("event_seen", 16'h1, {15'h0, seen});
		cyc(7000);
		chk("radio_mode", 16'h1, {14'h0, u_rts_if.radio_mode});
		pulse(2);
		wait_mode(RTS_RADIO_SLEEP, 20);
		// Sync listen: short window, preamble extends it, sync word stops it
		run(2'h1, 8'h01, 8'h02, 8'h01);
		chk("after_rx", 16'h5, {13'h0, u_rts_if.after_rx_transition});
		wait_mode(RTS_RADIO_RX, 20000);
		wait_mode(RTS_RADIO_SLEEP, 6500);
		// Low power must cover the rest of T1+T2, not only T1
		cyc(12000);
		chk("rest_sleep", 16'h0, {14'h0, u_rts_if.radio_mode});
		wait_mode(RTS_RADIO_RX, 20000);
		pulse(3);
		cyc(6500);
		chk("radio_mode", 16'h1, {14'h0, u_rts_if.radio_mode});
		pulse(4);
		cyc(8);
		chk("pin_two", 16'h1, {15'h0, u_rts_if.irq_pin_two});
		pulse(5);
		cyc(8);
		chk("packet_irq", 16'h1, {15'h0, u_rts_if.packet_irq});
		cyc(7000);
		chk("radio_mode", 16'h1, {14'h0, u_rts_if.radio_mode});
		pulse(2);
		wait_mode(RTS_RADIO_SLEEP, 20);
		// Beacon: transmit, back to idle on done, loops until halted
		run(2'h2, 8'h01, 8'h01, 8'h01);
		chk("beacon_en", 16'h1, {15'h0, u_rts_if.repeat_tx_enable});
		chk("after_tx", 16'h0, {15'h0, u_rts_if.after_tx_transition});
		wait_mode(RTS_RADIO_TX, 20000);
		chk("tx_launch", 16'h1, {15'h0, tx_launch});
		pulse(6);
		wait_mode(RTS_RADIO_SLEEP, 10);
		cyc(2);
		chk("rc_only", 16'h1, {15'h0, rc_only});
		// Next transmit comes a full T1+T2 after the last one began
		cyc(8000);
		chk("beacon_gap", 16'h0, {14'h0, u_rts_if.radio_mode});
		wait_mode(RTS_RADIO_TX, 20000);
		pulse(6);
		pulse(1);
		cyc(4);
		chk("halt", 16'h1, {15'h0, u_rts_if.seq_halt_bit});
		chk("seq_running", 16'h0, {15'h0, u_rts_if.seq_running});
		chk("radio_mode", 16'h0, {14'h0, u_rts_if.radio_mode});
		conclude();
	end
endmodule
`default_nettype wire
